// ---- verilog/crank_pkg.sv ----
package crank_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register addresses on the serial port (7-bit address field)
    localparam logic [6:0] ADDR_RUNNING  = 7'h10;
    localparam logic [6:0] ADDR_CRANKING = 7'h11;
    localparam logic [6:0] ADDR_MISC     = 7'h12;
    localparam logic [6:0] ADDR_AUTO     = 7'h13;
    localparam logic [6:0] ADDR_TACH     = 7'h14;
    localparam logic [6:0] ADDR_STATUS   = 7'h15;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [7:0] RUNNING_RST  = 8'h50;
    localparam logic [7:0] CRANKING_RST = 8'h00;
    localparam logic [7:0] MISC_RST     = 8'h00;
    localparam logic [7:0] AUTO_RST     = 8'h00;
    localparam logic [7:0] TACH_RST     = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // field positions and fixed figures
    localparam int         THRESH_LSB      = 4;
    localparam int         BLANK_LSB       = 0;
    localparam logic [3:0] THRESH_MAX      = 4'hf;
    localparam int         BLANK_SHIFT     = 5;
    localparam int         SPI_CMD_BITS    = 8;
    localparam int         SPI_FRAME_BITS  = 16;
    localparam int         WRITE_BIT       = 7;
    localparam int         MANTISSA_OFFSET = 16;
    localparam int         CLK_PERIOD_NS   = 40;
    localparam int         DECAY_TICK_NS   = 1000;
    localparam int         DECAY_TICK_CYCLES =
        (DECAY_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [3:0] thresh;
        logic [3:0] blank;
    } param_set_t;

    typedef struct packed {
        logic       auto_en;
        logic       rsvd6;
        logic       hilo_ref;
        logic       invert;
        logic [3:0] rsvd;
    } misc_cfg_t;

    typedef struct packed {
        logic [3:0] mant;
        logic [3:0] expo;
    } auto_cfg_t;

    typedef enum logic [1:0] {
        TH_FIXED = 2'b01,
        TH_DECAY = 2'b10
    } thr_state_t;

endpackage : crank_pkg

// ---- verilog/blanking_one_shot.sv ----
`timescale 1ns/1ps

module blanking_one_shot
    import crank_pkg::*;
#(
    parameter int CNT_W = 16
)(
    input  wire logic             mclk,
    input  wire logic             srst,
    input  wire logic             raw_in,
    input  wire logic [3:0]       blank_code,
    input  wire logic             hilo_ref,
    output logic                  pulse_out,
    output logic                  blanking,
    output logic [CNT_W-1:0]      ref_len
);

    generate
        if (CNT_W < 8 || CNT_W > 24)
        begin : g_chk
            $error("blanking_one_shot: CNT_W must be 8 to 24");
        end
    endgenerate

    // window = reference * code / 32, i.e. 3.125 percent per step
    function automatic logic [CNT_W-1:0] blank_len(input logic [CNT_W-1:0] len,
                                                  input logic [3:0] code);
        logic [CNT_W+3:0] prod;
        prod = {4'h0, len} * {{CNT_W{1'b0}}, code};
        return CNT_W'(prod >> BLANK_SHIFT);
    endfunction : blank_len

    logic [CNT_W-1:0] win_cnt;
    logic [CNT_W-1:0] meas_cnt;
    logic [CNT_W-1:0] next_win_cnt;
    logic [CNT_W-1:0] next_meas_cnt;
    logic [CNT_W-1:0] next_ref_len;
    logic             next_pulse_out;
    logic             next_blanking;
    logic             meas_level;

    always_comb
    begin
        meas_level     = ~hilo_ref;
        next_pulse_out = pulse_out;
        next_win_cnt   = win_cnt;
        next_ref_len   = ref_len;
        next_meas_cnt  = meas_cnt;
        if (pulse_out == meas_level && meas_cnt != {CNT_W{1'b1}})
        begin
            next_meas_cnt = meas_cnt + 1'b1;
        end
        if (win_cnt != '0)
        begin
            // inside the window the comparator is ignored
            next_win_cnt = win_cnt - 1'b1;
        end
        else if (raw_in != pulse_out)
        begin
            next_pulse_out = raw_in;
            if (pulse_out == meas_level)
            begin
                next_ref_len = meas_cnt;
                next_win_cnt = blank_len(meas_cnt, blank_code);
            end
            else
            begin
                next_win_cnt = blank_len(ref_len, blank_code);
            end
            if (raw_in == meas_level)
            begin
                next_meas_cnt = '0;
            end
        end
        next_blanking = (next_win_cnt != '0);
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            pulse_out <= 1'b0;
            blanking  <= 1'b0;
            win_cnt   <= '0;
            meas_cnt  <= '0;
            ref_len   <= '0;
        end
        else
        begin
            pulse_out <= next_pulse_out;
            blanking  <= next_blanking;
            win_cnt   <= next_win_cnt;
            meas_cnt  <= next_meas_cnt;
            ref_len   <= next_ref_len;
        end
    end

endmodule : blanking_one_shot

// ---- verilog/crank_conditioner.sv ----
`timescale 1ns/1ps

// Functional notes
// - two writable parameter sets, cranking and running, each threshold plus blanking code.
// - cranking set all zero means the running set is applied.
// - any non-zero cranking set is applied instead of the running set.
// - comparator threshold comes from a 4-bit code driving the internal converter.
// - threshold code sits in bits 7 to 4; code 0101 is the default.
// - one-shot blanking after each output switch, fraction of last pulse.
// - conditioned output can be divided onto a separate tachometer pin.
// - optional automatic threshold that follows the input amplitude.
// - digitized comparator result drives the conditioned pulse output.
// - blanking code in bits 3 to 0, 3.125 percent per step, zero none.
// - a reference select bit switches blanking reference to the low pulse.
module crank_conditioner
    import crank_pkg::*;
#(
    parameter int CNT_W      = 16,
    parameter int DECAY_TICK = DECAY_TICK_CYCLES
)(
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_sclk,
    input  wire logic       spi_mosi,
    output logic            spi_miso,
    output logic            spi_miso_oe_n,
    input  wire logic       comp_in,
    input  wire logic       zero_cross,
    output logic [3:0]      threshold_code,
    output logic            conditioned_pulse_out,
    output logic            divided_speed_out
);

    generate
        if (DECAY_TICK < 1 || DECAY_TICK > 65535)
        begin : g_chk
            $error("crank_conditioner: DECAY_TICK must be 1 to 65535");
        end
    endgenerate

    // cranking set wins as soon as any of its bits is set
    function automatic param_set_t select_set(input param_set_t running,
                                              input param_set_t cranking);
        return (cranking != '0) ? cranking : running;
    endfunction : select_set

    function automatic logic [7:0] read_mux(input logic [6:0] addr,
                                            input logic [7:0] running,
                                            input logic [7:0] cranking,
                                            input logic [7:0] misc,
                                            input logic [7:0] auto_p,
                                            input logic [7:0] tach,
                                            input logic [7:0] status);
        case (addr)
            ADDR_RUNNING:  return running;
            ADDR_CRANKING: return cranking;
            ADDR_MISC:     return misc;
            ADDR_AUTO:     return auto_p;
            ADDR_TACH:     return tach;
            ADDR_STATUS:   return status;
            default:       return 8'h00;
        endcase
    endfunction : read_mux

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    param_set_t       running_params;
    param_set_t       cranking_params;
    misc_cfg_t        misc_cfg;
    auto_cfg_t        auto_cfg;
    logic [7:0]       tach_div;
    param_set_t       next_running_params;
    param_set_t       next_cranking_params;
    misc_cfg_t        next_misc_cfg;
    auto_cfg_t        next_auto_cfg;
    logic [7:0]       next_tach_div;
    param_set_t       active_set;
    logic             crank_active;
    logic [7:0]       status_word;

    logic             sclk_q;
    logic [4:0]       bit_cnt;
    logic [7:0]       rx_shift;
    logic [7:0]       cmd_q;
    logic [7:0]       tx_shift;
    logic             wr_pulse;
    logic [6:0]       wr_addr;
    logic [7:0]       wr_data;
    logic             next_sclk_q;
    logic [4:0]       next_bit_cnt;
    logic [7:0]       next_rx_shift;
    logic [7:0]       next_cmd_q;
    logic [7:0]       next_tx_shift;
    logic             next_spi_miso;
    logic             next_spi_miso_oe_n;
    logic             next_wr_pulse;
    logic [6:0]       next_wr_addr;
    logic [7:0]       next_wr_data;

    thr_state_t       thr_state;
    thr_state_t       next_thr_state;
    logic [15:0]      tick_cnt;
    logic [15:0]      next_tick_cnt;
    logic [19:0]      step_cnt;
    logic [19:0]      next_step_cnt;
    logic [19:0]      step_len;
    logic [3:0]       next_threshold_code;
    logic             tick;

    logic             cond_q;
    logic [7:0]       tach_cnt;
    logic             next_cond_q;
    logic [7:0]       next_tach_cnt;
    logic             next_divided_speed_out;

    logic             comp_oriented;
    logic             blanking;

    ////////////////////////////////////////////////////////////////////////////
    // serial register port: 16-bit frames, mode 0, command byte then data

    always_comb
    begin
        next_sclk_q        = spi_sclk;
        next_bit_cnt       = bit_cnt;
        next_rx_shift      = rx_shift;
        next_cmd_q         = cmd_q;
        next_tx_shift      = tx_shift;
        next_spi_miso      = spi_miso;
        next_spi_miso_oe_n = spi_cs_n;
        next_wr_pulse      = 1'b0;
        next_wr_addr       = wr_addr;
        next_wr_data       = wr_data;
        if (spi_cs_n)
        begin
            next_bit_cnt  = 5'h00;
            next_spi_miso = 1'b0;
        end
        else if (spi_sclk && !sclk_q && bit_cnt < 5'(SPI_FRAME_BITS))
        begin
            next_rx_shift = {rx_shift[6:0], spi_mosi};
            next_bit_cnt  = bit_cnt + 5'h01;
            if (bit_cnt == 5'(SPI_CMD_BITS - 1))
            begin
                next_cmd_q    = {rx_shift[6:0], spi_mosi};
                next_tx_shift = read_mux(next_cmd_q[6:0], running_params,
                                         cranking_params, misc_cfg, auto_cfg,
                                         tach_div, status_word);
            end
            if (bit_cnt == 5'(SPI_FRAME_BITS - 1) && cmd_q[WRITE_BIT])
            begin
                // a write lands only when all sixteen bits arrived
                next_wr_pulse = 1'b1;
                next_wr_addr  = cmd_q[6:0];
                next_wr_data  = {rx_shift[6:0], spi_mosi};
            end
        end
        else if (!spi_sclk && sclk_q)
        begin
            if (bit_cnt >= 5'(SPI_CMD_BITS) && bit_cnt < 5'(SPI_FRAME_BITS))
            begin
                next_spi_miso = tx_shift[7];
                next_tx_shift = {tx_shift[6:0], 1'b0};
            end
            else
            begin
                next_spi_miso = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            sclk_q        <= 1'b0;
            bit_cnt       <= 5'h00;
            rx_shift      <= 8'h00;
            cmd_q         <= 8'h00;
            tx_shift      <= 8'h00;
            spi_miso      <= 1'b0;
            spi_miso_oe_n <= 1'b1;
            wr_pulse      <= 1'b0;
            wr_addr       <= 7'h00;
            wr_data       <= 8'h00;
        end
        else
        begin
            sclk_q        <= next_sclk_q;
            bit_cnt       <= next_bit_cnt;
            rx_shift      <= next_rx_shift;
            cmd_q         <= next_cmd_q;
            tx_shift      <= next_tx_shift;
            spi_miso      <= next_spi_miso;
            spi_miso_oe_n <= next_spi_miso_oe_n;
            wr_pulse      <= next_wr_pulse;
            wr_addr       <= next_wr_addr;
            wr_data       <= next_wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_comb
    begin
        next_running_params  = running_params;
        next_cranking_params = cranking_params;
        next_misc_cfg        = misc_cfg;
        next_auto_cfg        = auto_cfg;
        next_tach_div        = tach_div;
        if (wr_pulse)
        begin
            case (wr_addr)
                ADDR_RUNNING:  next_running_params  = wr_data;
                ADDR_CRANKING: next_cranking_params = wr_data;
                ADDR_MISC:     next_misc_cfg        = wr_data;
                ADDR_AUTO:     next_auto_cfg        = wr_data;
                ADDR_TACH:     next_tach_div        = wr_data;
                default:       next_tach_div        = tach_div;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            running_params  <= RUNNING_RST;
            cranking_params <= CRANKING_RST;
            misc_cfg        <= MISC_RST;
            auto_cfg        <= AUTO_RST;
            tach_div        <= TACH_RST;
        end
        else
        begin
            running_params  <= next_running_params;
            cranking_params <= next_cranking_params;
            misc_cfg        <= next_misc_cfg;
            auto_cfg        <= next_auto_cfg;
            tach_div        <= next_tach_div;
        end
    end

    // controller is expected to clear cranking once running; nothing forces it
    assign active_set   = select_set(running_params, cranking_params);
    assign crank_active = (cranking_params != '0);
    assign status_word  = {threshold_code, 1'b0, blanking, crank_active,
                           conditioned_pulse_out};

    ////////////////////////////////////////////////////////////////////////////
    // threshold code: fixed from the active set, or jump-and-decay in auto

    assign tick     = (tick_cnt == 16'(DECAY_TICK - 1));
    assign step_len = 20'({15'h0000, 5'(MANTISSA_OFFSET) + {1'b0, auto_cfg.mant}}
                          << auto_cfg.expo);

    always_comb
    begin
        next_thr_state      = thr_state;
        next_threshold_code = threshold_code;
        next_step_cnt       = step_cnt;
        next_tick_cnt       = tick ? 16'h0000 : tick_cnt + 16'h0001;
        case (thr_state)
            TH_FIXED:
            begin
                next_threshold_code = active_set.thresh;
                next_step_cnt       = 20'h0_0000;
                if (misc_cfg.auto_en && zero_cross)
                begin
                    next_threshold_code = THRESH_MAX;
                    next_thr_state      = TH_DECAY;
                end
            end
            TH_DECAY:
            begin
                if (!misc_cfg.auto_en)
                begin
                    next_thr_state = TH_FIXED;
                end
                else if (zero_cross)
                begin
                    next_threshold_code = THRESH_MAX;
                    next_step_cnt       = 20'h0_0000;
                end
                else if (tick)
                begin
                    next_step_cnt = step_cnt + 20'h0_0001;
                    if (next_step_cnt >= step_len)
                    begin
                        // one code per step keeps the decay roughly linear
                        next_step_cnt = 20'h0_0000;
                        if (threshold_code > active_set.thresh)
                        begin
                            next_threshold_code = threshold_code - 4'h1;
                        end
                        else
                        begin
                            next_thr_state = TH_FIXED;
                        end
                    end
                end
            end
            default:
            begin
                next_thr_state = TH_FIXED;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            thr_state      <= TH_FIXED;
            threshold_code <= RUNNING_RST[7:THRESH_LSB];
            step_cnt       <= 20'h0_0000;
            tick_cnt       <= 16'h0000;
        end
        else
        begin
            thr_state      <= next_thr_state;
            threshold_code <= next_threshold_code;
            step_cnt       <= next_step_cnt;
            tick_cnt       <= next_tick_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // comparator conditioning

    // inversion stands for swapping the two sensor legs
    assign comp_oriented = comp_in ^ misc_cfg.invert;

    blanking_one_shot #(
        .CNT_W      (CNT_W)
    ) u_blank (
        .mclk       (mclk),
        .srst       (srst),
        .raw_in     (comp_oriented),
        .blank_code (active_set.blank),
        .hilo_ref   (misc_cfg.hilo_ref),
        .pulse_out  (conditioned_pulse_out),
        .blanking   (blanking),
        .ref_len    ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // tachometer divider: toggles every tach_div rising edges, zero holds low

    always_comb
    begin
        next_cond_q            = conditioned_pulse_out;
        next_tach_cnt          = tach_cnt;
        next_divided_speed_out = divided_speed_out;
        if (tach_div == 8'h00)
        begin
            next_tach_cnt          = 8'h00;
            next_divided_speed_out = 1'b0;
        end
        else if (conditioned_pulse_out && !cond_q)
        begin
            if (tach_cnt >= tach_div - 8'h01)
            begin
                next_tach_cnt          = 8'h00;
                next_divided_speed_out = ~divided_speed_out;
            end
            else
            begin
                next_tach_cnt = tach_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cond_q            <= 1'b0;
            tach_cnt          <= 8'h00;
            divided_speed_out <= 1'b0;
        end
        else
        begin
            cond_q            <= next_cond_q;
            tach_cnt          <= next_tach_cnt;
            divided_speed_out <= next_divided_speed_out;
        end
    end

endmodule : crank_conditioner

// ---- verification/crank_conditioner_asserts.sv ----
`timescale 1ns/1ps
module crank_conditioner_chk
    import crank_pkg::*;
#(
    parameter int CNT_W      = 16,
    parameter int DECAY_TICK = DECAY_TICK_CYCLES
)(
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic       spi_cs_n,
    input wire logic       spi_sclk,
    input wire logic       spi_mosi,
    input wire logic       spi_miso,
    input wire logic       spi_miso_oe_n,
    input wire logic       comp_in,
    input wire logic       zero_cross,
    input wire logic [3:0] threshold_code,
    input wire logic       conditioned_pulse_out,
    input wire logic       divided_speed_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    //////////////////////////////////////////////////////////////
    // short histories, so an answer may land a cycle or two late
    logic       sclk_q;
    logic       out_q;
    logic [3:0] fall_hist;
    logic [2:0] rise_hist;
    logic [7:0] cs_hist;
    logic [4:0] bits;
    logic [4:0] next_bits;
    always_comb
    begin
        next_bits = bits;
        if (spi_cs_n)
            next_bits = 5'h0;
        else if (spi_sclk && !sclk_q && bits < 5'h10)
            next_bits = bits + 5'h1;
    end
    always_ff @(posedge mclk)
    begin
        sclk_q    <= spi_sclk;
        out_q     <= conditioned_pulse_out;
        bits      <= next_bits;
        fall_hist <= {fall_hist[2:0], sclk_q & ~spi_sclk};
        rise_hist <= {rise_hist[1:0], conditioned_pulse_out & ~out_q};
        cs_hist   <= {cs_hist[6:0], ~spi_cs_n};
    end
    //////////////////////////////////////////////////////////////
    sequence s_quiet_move;
        $changed(threshold_code) && cs_hist == 8'h00;
    endsequence
    property p_rst_vals;
        $fell(srst) |-> threshold_code == 4'h5 && !conditioned_pulse_out && !divided_speed_out;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
    property p_oe_copy; spi_miso_oe_n == $past(spi_cs_n); endproperty
    a_oe_copy: assert property (p_oe_copy) else $error("miso enable off");
    property p_miso_cmd; !spi_cs_n && bits < 5'h8 |-> !spi_miso; endproperty
    a_miso_cmd: assert property (p_miso_cmd) else $error("miso busy in command");
    property p_miso_move; $changed(spi_miso) |-> (|fall_hist) || $past(spi_cs_n); endproperty
    a_miso_move: assert property (p_miso_move) else $error("miso moved alone");
    property p_out_cause;
        $changed(conditioned_pulse_out) |-> conditioned_pulse_out == $past(comp_in);
    endproperty
    a_out_cause: assert property (p_out_cause) else $error("output moved alone");
    property p_tach; $changed(divided_speed_out) |-> (|rise_hist); endproperty
    a_tach: assert property (p_tach) else $error("tach moved alone");
    property p_thr_step;
        s_quiet_move |-> threshold_code == 4'hf || threshold_code == $past(threshold_code) - 4'h1;
    endproperty
    a_thr_step: assert property (p_thr_step) else $error("threshold jumped");
    property p_thr_top;
        s_quiet_move ##0 threshold_code == 4'hf |-> $past(zero_cross) || $past(zero_cross, 2);
    endproperty
    a_thr_top: assert property (p_thr_top) else $error("threshold top unasked");
endmodule : crank_conditioner_chk

bind crank_conditioner crank_conditioner_chk #(.DECAY_TICK(DECAY_TICK))
u_crank_conditioner_chk (.mclk(mclk), .srst(srst), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe_n(spi_miso_oe_n), .comp_in(comp_in), .zero_cross(zero_cross),
    .threshold_code(threshold_code), .conditioned_pulse_out(conditioned_pulse_out),
    .divided_speed_out(divided_speed_out));

// ---- verification/crank_far_side.sv ----
`timescale 1ns/1ps
module crank_far_side (
    input  wire logic mclk,
    input  wire logic spi_miso,
    output logic      spi_cs_n,
    output logic      spi_sclk,
    output logic      spi_mosi,
    output logic      comp_in,
    output logic      zero_cross
);
    initial
    begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
        comp_in = 1'b0;
        zero_cross = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    // low phase of 3 so the registered miso has settled before the rise
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
        spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            spi_mosi = tx[i];
            step(3);
            if (i < 8)
                rx[i] = spi_miso;
            spi_sclk = 1'b1;
            step(2);
            spi_sclk = 1'b0;
        end
        step(2);
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi; // deselected line shows no stale bit
        step(2);
    endtask : xfer
    task automatic level(input logic v, input int n);
        comp_in = v;
        step(n);
    endtask : level
    task automatic zc();
        zero_cross = 1'b1;
        step(1);
        zero_cross = 1'b0;
    endtask : zc
endmodule : crank_far_side

// ---- verification/test_crank_conditioner.sv ----
`timescale 1ns/1ps
module test_crank_conditioner
    import crank_pkg::*;
;
    logic       mclk;
    logic       srst;
    logic       cs_n;
    logic       sclk;
    logic       mosi;
    logic       miso;
    logic       miso_oe_n;
    logic       comp;
    logic       zcr;
    logic [3:0] thr;
    logic       pulse;
    logic       tach;
    logic [7:0] rd;
    int         err_total = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    wire        miso_line = miso_oe_n ? 1'b1 : miso; // pulled up while released

    crank_conditioner #(.DECAY_TICK(1)) u_crank_conditioner (.mclk(mclk),
        .srst(srst), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso),
        .spi_miso_oe_n(miso_oe_n), .comp_in(comp), .zero_cross(zcr), .threshold_code(thr),
        .conditioned_pulse_out(pulse), .divided_speed_out(tach));
    crank_far_side u_crank_far_side (.mclk(mclk), .spi_miso(miso_line), .spi_cs_n(cs_n),
        .spi_sclk(sclk), .spi_mosi(mosi), .comp_in(comp), .zero_cross(zcr));
    //////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_crank_far_side.xfer({1'b1, a, d}, rd);
        u_crank_far_side.step(4);
    endtask : wr
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        u_crank_far_side.xfer({1'b0, a, 8'h00}, rd);
        chk(rd, exp);
    endtask : rd_chk
    task automatic t_params();
        chk({4'h0, thr}, 8'h05);
        rd_chk(ADDR_RUNNING, 8'h50);
        rd_chk(ADDR_CRANKING, 8'h00);
        rd_chk(7'h7f, 8'h00);
        rd_chk(ADDR_STATUS, 8'h50);
        wr(ADDR_CRANKING, 8'h3c);
        chk({4'h0, thr}, 8'h03);
        rd_chk(ADDR_STATUS, 8'h32);
        // blanking bit alone still makes the cranking set win
        wr(ADDR_CRANKING, 8'h01);
        wr(ADDR_RUNNING, 8'ha0);
        chk({4'h0, thr}, 8'h00);
        rd_chk(ADDR_CRANKING, 8'h01);
        wr(ADDR_CRANKING, 8'h00);
        for (int c = 0; c < 16; c++)
        begin
            wr(ADDR_RUNNING, {c[3:0], 4'h0});
            chk({4'h0, thr}, {4'h0, c[3:0]});
        end
        rd_chk(ADDR_RUNNING, 8'hf0);
    endtask : t_params
    task automatic t_blank(input logic [7:0] misc, input logic [7:0] run, input logic exp);
        wr(ADDR_MISC, misc);
        wr(ADDR_RUNNING, run);
        u_crank_far_side.level(1'b1, 64);
        u_crank_far_side.level(1'b0, 8);
        u_crank_far_side.level(1'b1, 64);
        u_crank_far_side.level(1'b0, 6);
        u_crank_far_side.level(1'b1, 4);
        chk({7'h0, pulse}, {7'h0, exp});
        u_crank_far_side.level(1'b0, 40);
    endtask : t_blank
    task automatic t_tach();
        int   flips;
        logic last;
        chk({7'h0, tach}, 8'h00);
        wr(ADDR_TACH, 8'h02);
        flips = 0;
        last = tach;
        for (int i = 0; i < 4; i++)
        begin
            u_crank_far_side.level(1'b1, 10);
            u_crank_far_side.level(1'b0, 10);
            flips += (tach !== last);
            last = tach;
        end
        chk(flips[7:0], 8'h02);
    endtask : t_tach
    task automatic t_auto();
        wr(ADDR_RUNNING, 8'h90);
        wr(ADDR_AUTO, 8'h00);
        wr(ADDR_MISC, 8'h80);
        u_crank_far_side.step(2);
        u_crank_far_side.zc();
        u_crank_far_side.step(1);
        chk({4'h0, thr}, 8'h0f);
        u_crank_far_side.step(150);
        chk({4'h0, thr}, 8'h09);
        wr(ADDR_MISC, 8'h00);
    endtask : t_auto
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    //////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            err_total++;
            wrap_up();
        end
    end
    initial
    begin
        srst = 1'b1;
        repeat (10) @(posedge mclk);
        #1;
        srst = 1'b0;
        u_crank_far_side.step(1);
        t_params();
        t_blank(8'h00, 8'h58, 1'b0);
        t_blank(8'h20, 8'h51, 1'b1);
        t_blank(8'h00, 8'h50, 1'b1);
        t_tach();
        t_auto();
        wrap_up();
    end
endmodule : test_crank_conditioner
